// file: core/rtcsa_pkg.sv
package rtcsa_pkg;

  // ****************************************
  // Protocol constants
  // ****************************************
  localparam logic [3:0] RTCSA_DEV_CODE = 4'h6;
  localparam logic [2:0] RTCSA_CMD_STAT = 3'h0;
  localparam logic [2:0] RTCSA_CMD_INT = 3'h4;
  localparam logic [2:0] RTCSA_CMD_INTF = 3'h4;
  localparam int RTCSA_ALARM_BYTES = 3;
  localparam int RTCSA_PLAIN_BYTES = 1;
  localparam int RTCSA_BIT_MSB = 7;

  // ****************************************
  // Status register and interrupt register fields and reset values
  // ****************************************
  localparam int RTCSA_ST2_INTERRUPT_OUTPUT_ONE_MODE_LO = 5;
  localparam logic [2:0] RTCSA_MODE_ALARM = 3'h2;
  localparam logic [2:0] RTCSA_MODE_FREQ = 3'h4;
  localparam logic [7:0] RTCSA_ST1_RST = 8'h80;
  localparam logic [7:0] RTCSA_ST2_RST = 8'h00;
  localparam logic [7:0] RTCSA_INT_RST = 8'h00;
  localparam int RTCSA_ST1_POC_BIT = 7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int RTCSA_CLK_MHZ = 250;
  localparam int RTCSA_POR_HZ = 1;
  localparam int RTCSA_HALF_CYC = RTCSA_CLK_MHZ * 1000000 / (2 * RTCSA_POR_HZ);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [5:0] {
    RTCSA_IDLE = 6'h01,
    RTCSA_ADDR = 6'h02,
    RTCSA_AACK = 6'h04,
    RTCSA_WR = 6'h08,
    RTCSA_RD = 6'h10,
    RTCSA_RACK = 6'h20
  } rtcsa_state_e;

  typedef struct packed {
    logic o;
    logic oe_n;
  } rtcsa_pin_s;

endpackage

// file: core/rtcsa_mem.sv
`timescale 1ns/100ps
module rtcsa_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem_q [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule // rtcsa_mem

// file: core/rtcsa_top.sv
`timescale 1ns/100ps
// Contract
// R1: Master programs status register 2 before touching interrupt registers.
// R2: Alarm mode makes each interrupt register three bytes, else one byte.
// R3: Frequency mode makes interrupt registers hold the output frequency data.
// R4: Master never uses alarm 1 and user frequency on outputs together.
// R5: Command select bit 0 picks status register 1, 1 picks register 2.
// R6: Command select bit 0 picks interrupt register 1, 1 picks register 2.
// R7: Master answers last read byte with not-acknowledge, bit high.
// R8: Master acknowledges every read byte but the last with bit low.
// R9: Interrupted transfer keeps its state until the interface is reset.
// R10: No reset pin; a stop returns the serial interface to idle.
// R11: Start and stop are ignored while the device pulls data low.
// R12: Recovery begins with a start that the device may miss.
// R13: Master then gives 63 clocks so pending device output finishes.
// R14: Master keeps data released during recovery clocks.
// R15: Stop after recovery releases data and resets the interface.
// R16: Master should run recovery at system initialization.
// R17: Recovery during a write acknowledge may complete that write.
// R18: Master waits 0.5 s after power-on before communicating.
// R19: Master reads first real-time group back within 1 s of writing.
// R20: Power-on detection drives a 1 Hz signal on interrupt output one.
// R21: The 1 Hz output runs until the device is initialized.
// R22: Read/write bit 1 enters read mode, 0 enters write mode.
// R23: Data bytes shift most significant bit first from bit 7.
module rtcsa_top
  import rtcsa_pkg::*;
#(
  parameter int HALF_CYC = RTCSA_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Interrupt outputs, open drain
  output logic interrupt_output_one_oe_n,
  output logic interrupt_output_two_oe_n,
  // Status
  output logic [7:0] status2_q,
  output logic por_active_q
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] scl_s_q, sda_s_q;
  logic scl_q, sda_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      if (scl_s_q[1] == scl_s_q[2]) begin
        scl_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        sda_q <= sda_s_q[2];
      end
    end
  end
  logic scl_d1_q, sda_d1_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_q;
      sda_d1_q <= sda_q;
    end
  end
  logic scl_rise, scl_fall, driving_low, start_c, stop_c;
  assign scl_rise = scl_q & ~scl_d1_q;
  assign scl_fall = ~scl_q & scl_d1_q;
  assign driving_low = ~sda_oe_n & ~sda_o;
  // Conditions only seen while our driver is off
  assign start_c = scl_q & scl_d1_q & sda_d1_q & ~sda_q & ~driving_low; // [R11]
  assign stop_c = scl_q & scl_d1_q & ~sda_d1_q & sda_q & ~driving_low; // [R11] [R10]

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [1:0] reg_len(input logic [7:0] st2, input logic sel);
    logic [2:0] md;
    md = sel ? st2[2:0] : st2[RTCSA_ST2_INTERRUPT_OUTPUT_ONE_MODE_LO +: 3];
    reg_len = (md == RTCSA_MODE_ALARM) ? 2'(RTCSA_ALARM_BYTES)
                                       : 2'(RTCSA_PLAIN_BYTES); // [R2]
  endfunction

  // ****************************************
  // Serial engine
  // ****************************************
  rtcsa_state_e st_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [2:0] cmd_q;
  logic rw_q, hit_q;
  logic [1:0] idx_q;
  logic [7:0] st1_q;
  logic we;
  logic [2:0] waddr, raddr;
  logic [7:0] rdata;
  logic [1:0] len;
  assign len = reg_len(status2_q, cmd_q[0]);
  // Memory: word = {sel, idx}; interrupt register bytes
  assign raddr = {cmd_q[0], idx_q};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= RTCSA_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      cmd_q <= 3'h0;
      rw_q <= 1'b0;
      hit_q <= 1'b0;
      idx_q <= 2'h0;
    end else if (stop_c) begin
      st_q <= RTCSA_IDLE; // [R10] [R15]
    end else if (start_c) begin
      st_q <= RTCSA_ADDR;
      bit_q <= 3'h0;
      idx_q <= 2'h0;
    end else begin
      // State held across any interruption until stop or start [R9]
      case (st_q)
        RTCSA_IDLE: begin
        end
        RTCSA_ADDR: if (scl_rise) begin
          sh_q <= {sh_q[6:0], sda_q}; // [R23]
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            hit_q <= sh_q[6:3] == RTCSA_DEV_CODE;
            cmd_q <= sh_q[2:0];
            rw_q <= sda_q; // [R22]
            st_q <= RTCSA_AACK;
          end
        end
        RTCSA_AACK: if (scl_fall && !sda_oe_n) begin
          st_q <= !hit_q ? RTCSA_IDLE : rw_q ? RTCSA_RD : RTCSA_WR; // [R22]
        end else if (scl_fall && !hit_q) begin
          st_q <= RTCSA_IDLE;
        end
        RTCSA_WR: if (scl_rise) begin
          sh_q <= {sh_q[6:0], sda_q}; // [R23]
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_q <= RTCSA_AACK;
            rw_q <= 1'b0;
          end
        end
        RTCSA_RD: if (scl_rise) begin
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_q <= RTCSA_RACK;
          end
        end
        RTCSA_RACK: if (scl_rise) begin
          // Master high ends the read; low keeps going [R7] [R8]
          st_q <= sda_q ? RTCSA_IDLE : RTCSA_RD;
          idx_q <= (idx_q + 2'h1 >= len) ? 2'h0 : idx_q + 2'h1;
        end
        default: st_q <= RTCSA_IDLE;
      endcase
    end
  end

  // Byte write strobe on ninth-clock rise, also under recovery [R17]
  logic wr_done;
  assign wr_done = (st_q == RTCSA_AACK) && !rw_q && hit_q && scl_rise
                   && (bit_q == 3'h0) && !sda_oe_n;
  logic first_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_q <= 1'b1;
    end else if (start_c) begin
      first_q <= 1'b1;
    end else if (st_q == RTCSA_AACK && scl_fall && !sda_oe_n) begin
      first_q <= 1'b0;
    end
  end
  assign we = wr_done && !first_q && cmd_q[2:1] == RTCSA_CMD_INT[2:1];

  // Write-side byte index advance
  logic [1:0] widx_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      widx_q <= 2'h0;
    end else if (start_c) begin
      widx_q <= 2'h0;
    end else if (wr_done && !first_q) begin
      widx_q <= (widx_q + 2'h1 >= len) ? 2'h0 : widx_q + 2'h1;
    end
  end

  assign waddr = {cmd_q[0], widx_q}; // [R6]
  rtcsa_mem #(.DEPTH(8), .AW(3)) u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .we(we),
    .waddr(waddr),
    .wdata(sh_q), // [R3]
    .raddr(raddr),
    .rdata(rdata)
  );

  // ****************************************
  // Status registers
  // ****************************************
  logic stat_wr;
  assign stat_wr = wr_done && !first_q && cmd_q[2:1] == RTCSA_CMD_STAT[2:1];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st1_q <= RTCSA_ST1_RST;
      status2_q <= RTCSA_ST2_RST;
    end else if (stat_wr) begin
      if (cmd_q[0]) begin
        status2_q <= sh_q; // [R5]
      end else begin
        st1_q <= sh_q & ~(8'h01 << RTCSA_ST1_POC_BIT);
      end
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_active_q <= 1'b1;
    end else if (stat_wr && !cmd_q[0]) begin
      por_active_q <= 1'b0; // [R21]
    end
  end

  // ****************************************
  // Data line driver
  // ****************************************
  logic [7:0] rd_byte;
  always_comb begin
    if (cmd_q[2:1] == RTCSA_CMD_STAT[2:1]) begin
      rd_byte = cmd_q[0] ? status2_q : st1_q; // [R5]
    end else begin
      rd_byte = rdata; // [R6]
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_o <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (stop_c || start_c) begin
      sda_oe_n <= 1'b1;
    end else if (scl_fall) begin
      sda_oe_n <= 1'b1;
      // Acknowledge from the eighth fall to the ninth fall
      if (st_q == RTCSA_AACK && hit_q && sda_oe_n) begin
        sda_o <= 1'b0;
        sda_oe_n <= 1'b0;
      end
      if ((st_q == RTCSA_AACK && rw_q && hit_q && !sda_oe_n)
          || st_q == RTCSA_RD) begin
        sda_o <= rd_byte[3'(RTCSA_BIT_MSB) - bit_q]; // [R23]
        sda_oe_n <= rd_byte[3'(RTCSA_BIT_MSB) - bit_q];
      end
      if (st_q == RTCSA_RD && bit_q == 3'h0 && !sda_oe_n) begin
        sda_oe_n <= 1'b1;
      end
    end
  end

  // ****************************************
  // Power-on 1 Hz output
  // ****************************************
  logic [27:0] hz_cnt_q;
  logic hz_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hz_cnt_q <= 28'h0;
      hz_q <= 1'b0;
    end else if (hz_cnt_q == 28'(HALF_CYC - 1)) begin
      hz_cnt_q <= 28'h0;
      hz_q <= ~hz_q;
    end else begin
      hz_cnt_q <= hz_cnt_q + 28'h1;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_output_one_oe_n <= 1'b1;
      interrupt_output_two_oe_n <= 1'b1;
    end else begin
      interrupt_output_one_oe_n <= por_active_q ? hz_q : 1'b1; // [R20] [R21]
      interrupt_output_two_oe_n <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  por_out_a: assert property (@(posedge clk) disable iff (sys_rst) // [R21]
    !por_active_q |=> interrupt_output_one_oe_n)
    else $error("1 Hz output seen after init");
  por_tog_a: assert property (@(posedge clk) disable iff (sys_rst) // [R20]
    por_active_q && $changed(hz_q)
    |=> interrupt_output_one_oe_n == $past(hz_q))
    else $error("1 Hz output not following divider");
  stop_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    stop_c |=> st_q == RTCSA_IDLE)
    else $error("stop did not idle interface");
  no_cond_a: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
    driving_low && st_q == RTCSA_RD && !scl_fall |=> st_q != RTCSA_IDLE)
    else $error("condition taken while driving low");
  rel_stop_a: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
    stop_c |=> sda_oe_n)
    else $error("data not released after stop");
  hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
    !scl_rise && !scl_fall && !start_c && !stop_c |=> st_q == $past(st_q))
    else $error("state moved without bus event");
  rw_a: assert property (@(posedge clk) disable iff (sys_rst) // [R22]
    st_q == RTCSA_ADDR && scl_rise && bit_q == 3'h7 && !stop_c && !start_c
    |=> rw_q == $past(sda_q))
    else $error("direction bit not captured");
  len_a: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    len == ((cmd_q[0] ? status2_q[2:0] : status2_q[7:5]) == RTCSA_MODE_ALARM
    ? 2'h3 : 2'h1))
    else $error("register length wrong for mode");
  st_sel_a: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    stat_wr && cmd_q[0] |=> status2_q == $past(sh_q))
    else $error("status register 2 not selected");
endmodule // rtcsa_top

// file: verif/rtcsa_master.sv
`timescale 1ns/100ps
module rtcsa_master (
  // Bus
  output logic scl,
  output logic sda_oe_n,
  input wire logic sda
);
  localparam real HP = 62.5;
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  // ****************************************
  // Bus cycles
  // ****************************************
  task automatic start();
    #(HP/2) sda_oe_n = 1'b1;
    #(HP/2) scl = 1'b1;
    #HP sda_oe_n = 1'b0;
    #HP scl = 1'b0;
  endtask
  task automatic stop();
    #(HP/2) sda_oe_n = 1'b0;
    #(HP/2) scl = 1'b1;
    #HP sda_oe_n = 1'b1;
    #HP;
  endtask
  task automatic bit_cyc(input logic b, output logic s);
    #(HP/2) sda_oe_n = b;
    #(HP/2) scl = 1'b1;
    #(HP/2) s = sda;
    #(HP/2) scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
    bit_cyc(1'b1, ack);
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
    bit_cyc(last, s);
  endtask
  task automatic pulses(input int n);
    logic s;
    for (int i = 0; i < n; i++) bit_cyc(1'b1, s);
  endtask
endmodule // rtcsa_master

// file: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  import rtcsa_pkg::*;
  localparam int HC = 50;
  typedef struct packed {
    logic [2:0] cmd;
    logic [1:0] n;
    logic [23:0] d;
  } rtcsa_row_s;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, m_oe_n, sda, sda_o, sda_oe_n, i1_oe_n, i2_oe_n, por_q;
  logic [7:0] status2_q;
  logic a;
  logic [7:0] b;
  int error_cnt = 0;
  int tests_run = 0;
  rtcsa_row_s rows [8] = '{'{3'h1, 2'h1, 24'h000000},
    '{3'h4, 2'h1, 24'h5a0000}, '{3'h5, 2'h1, 24'ha50000},
    '{3'h1, 2'h1, 24'h400000}, '{3'h4, 2'h3, 24'h123456},
    '{3'h1, 2'h1, 24'h800000}, '{3'h4, 2'h1, 24'h3c0000},
    '{3'h1, 2'h1, 24'h020000}};
  assign sda = m_oe_n & (sda_oe_n | sda_o);
  always #2 clk = ~clk;
  rtcsa_top #(.HALF_CYC(HC)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .interrupt_output_one_oe_n(i1_oe_n),
    .interrupt_output_two_oe_n(i2_oe_n),
    .status2_q(status2_q), .por_active_q(por_q));
  rtcsa_master i_m (.scl(scl), .sda_oe_n(m_oe_n), .sda(sda));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic xfer(input logic rd, input rtcsa_row_s r);
    i_m.start();
    i_m.wr_byte({RTCSA_DEV_CODE, r.cmd, rd}, a);
    chk({7'h00, a}, 8'h00, "addr ack");
    for (int i = 0; i < r.n; i++) begin
      if (rd) begin
        i_m.rd_byte(i == r.n - 1, b);
        chk(b, r.d[23-8*i -: 8], "read byte");
      end else begin
        i_m.wr_byte(r.d[23-8*i -: 8], a);
        chk({7'h00, a}, 8'h00, "data ack");
      end
    end
    i_m.stop();
  endtask
  task automatic toggles(input logic [7:0] exp);
    logic [7:0] n;
    logic p;
    n = 8'h00;
    p = i1_oe_n;
    repeat (200) begin
      @(posedge clk);
      #1;
      if (i1_oe_n !== p) n++;
      p = i1_oe_n;
    end
    chk(n, exp, "one hz edges");
    chk({7'h00, i2_oe_n}, 8'h01, "int two idle");
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk({7'h00, por_q}, 8'h01, "por flag");
    toggles(8'h04);
    foreach (rows[i]) begin
      xfer(1'b0, rows[i]);
      if (rows[i].cmd == 3'h1)
        chk(status2_q, rows[i].d[23:16], "status2");
      xfer(1'b1, rows[i]);
    end
    xfer(1'b0, '{3'h0, 2'h1, 24'h000000});
    chk({7'h00, por_q}, 8'h00, "por cleared");
    toggles(8'h00);
    // Abandon a read while the device drives bit 7 low
    i_m.start();
    i_m.wr_byte({RTCSA_DEV_CODE, 3'h1, 1'b1}, a);
    #100;
    chk({7'h00, sda}, 8'h00, "held low");
    i_m.stop();
    chk({7'h00, sda}, 8'h00, "stop ignored");
    i_m.start();
    i_m.pulses(63);
    i_m.stop();
    #20;
    chk({7'h00, sda_oe_n}, 8'h01, "released");
    xfer(1'b1, '{3'h1, 2'h1, 24'h020000});
    i_m.start();
    i_m.wr_byte({4'h5, 3'h1, 1'b0}, a);
    chk({7'h00, a}, 8'h01, "foreign code");
    i_m.stop();
    xfer(1'b1, '{3'h1, 2'h1, 24'h020000});
    end_of_test();
  end
endmodule // testbench
